// ==== rlc_pkg.sv ====
// =====================================================================
// Shared constants and types for the revision / loop compensation bank
// =====================================================================
package rlc_pkg;

    // =================================================================
    // Command codes and transfer sizes
    // =================================================================
    localparam logic [7:0] RLC_CMD_SILICON_REV = 8'hae; // Revision word
    localparam logic [7:0] RLC_CMD_LOOP_COMP   = 8'hb1; // Compensation word
    localparam logic [7:0] RLC_REV_BYTES       = 8'h02; // Revision length
    localparam logic [7:0] RLC_COMP_BYTES      = 8'h05; // Compensation length
    localparam int         RLC_REV_W           = 16;    // Revision width
    localparam int         RLC_COMP_W          = 40;    // Compensation width

    // =================================================================
    // Revision word layout
    // =================================================================
    localparam int RLC_MAJOR_HI = 15;  // Major revision field
    localparam int RLC_MAJOR_LO = 12;
    localparam int RLC_MINOR_HI = 11;  // Minor revision field
    localparam int RLC_MINOR_LO = 8;
    localparam int RLC_SUBMN_HI = 7;   // Sub-minor revision field
    localparam int RLC_SUBMN_LO = 0;

    // =================================================================
    // Compensation word layout
    // =================================================================
    localparam int RLC_CZI_HI_H = 25;  // Current integ cap, upper pair
    localparam int RLC_CZI_HI_L = 24;
    localparam int RLC_CZI_LO_H = 39;  // Current integ cap, lower pair
    localparam int RLC_CZI_LO_L = 38;
    localparam int RLC_CPI_H    = 37;  // Current filter cap
    localparam int RLC_CPI_L    = 33;
    localparam int RLC_CZI_MUL  = 32;  // Current integ cap doubler
    localparam int RLC_RVI_H    = 31;  // Current gain resistor
    localparam int RLC_RVI_L    = 26;
    localparam int RLC_CZV_LO_H = 23;  // Voltage integ cap, lower pair
    localparam int RLC_CZV_LO_L = 22;
    localparam int RLC_CPV_H    = 21;  // Voltage filter cap
    localparam int RLC_CPV_L    = 17;
    localparam int RLC_RVV_H    = 15;  // Voltage gain resistor
    localparam int RLC_RVV_L    = 10;
    localparam int RLC_CZV_HI_H = 9;   // Voltage integ cap, upper pair
    localparam int RLC_CZV_HI_L = 8;
    localparam int RLC_GMV_H    = 5;   // Voltage transconductance
    localparam int RLC_GMV_L    = 4;
    localparam int RLC_GMI_H    = 1;   // Current transconductance
    localparam int RLC_GMI_L    = 0;

    // Reset contents before the first load event
    localparam logic [39:0] RLC_COMP_RESET = 40'h00_0000_0000;

    // =================================================================
    // Carriers
    // =================================================================
    typedef struct packed {
        logic [3:0] curIntegCapSel;     // Current integ cap selector
        logic [4:0] curFilterCapSel;    // Current filter cap selector
        logic       curIntegCapDoubler; // 1 doubles current integ cap
        logic [5:0] curGainResSel;      // Current gain resistor
        logic [3:0] voltIntegCapSel;    // Voltage integ cap selector
        logic [4:0] voltFilterCapSel;   // Voltage filter cap selector
        logic [5:0] voltGainResSel;     // Voltage gain resistor
        logic [1:0] voltTranscondSel;   // Voltage gm, scales CZV
        logic [1:0] curTranscondSel;    // Current gm, scales CZI
    } rlc_loop_sel_s;

    typedef struct packed {
        logic        valid;     // One-cycle command strobe
        logic        write;     // 1 block write, 0 block read
        logic [7:0]  code;      // Command code
        logic [7:0]  byteCount; // Block byte count of a write
        logic [39:0] data;      // Write data, byte 0 in bits 7:0
    } rlc_cmd_s;

    typedef struct packed {
        logic        valid;     // One-cycle answer strobe
        logic        accept;    // Command taken
        logic [7:0]  byteCount; // Bytes returned on a read
        logic [39:0] data;      // Read data, byte 0 in bits 7:0
    } rlc_rsp_s;

endpackage

// ==== rlc_bank.sv ====
// Operation
// - Revision answers only two-byte block reads
// - Revision fields major 15:12, minor 11:8, sub 7:0
// - Writing read-only command sets CML flags
// - Invalid command raises host fault notification
// - Compensation word is five-byte block access
// - Conversion off: written word applied immediately
// - Conversion on: word held, hardware update blocked
// - Load word from NVM or strap per override
// - Current integ cap from bits 25:24,39:38
// - Current filter cap from bits 37:33
// - Bit 32 doubles current integ cap
// - Current gain resistor from bits 31:26
// - Voltage integ cap from bits 9:8,23:22
// - Voltage filter cap from bits 21:17
// - Voltage gain resistor from bits 15:10
// - Voltage gm from bits 5:4
// - Current gm from bits 1:0
`timescale 1ns/10ps

module rlc_bank
    import rlc_pkg::*;
#(
    parameter logic [3:0] MAJOR_REVISION    = 4'h1,  // Arbitrary value
    parameter logic [3:0] MINOR_REVISION    = 4'h0,  // Arbitrary value
    parameter logic [7:0] SUBMINOR_REVISION = 8'h00  // Arbitrary value
) (
    input  wire logic          clk_sys,          // 10 MHz device clock
    input  wire logic          rstn,             // Async reset, active low
    input  wire rlc_cmd_s      cmdIn,            // Command from PMBus engine
    input  wire logic          conversionOn,     // Output conversion enabled
    input  wire logic          restoreLoad,      // Pulse: power-on or restore
    input  wire logic [39:0]   nvmWord,          // Word held in EEPROM
    input  wire logic [39:0]   strapWord,        // Word from strap detection
    input  wire logic          strapOverrideMask,// 0: take NVM, 1: take strap
    input  wire logic          clearFaults,      // Pulse: clear CML flags
    output rlc_rsp_s           rspOut,           // Answer to PMBus engine
    output rlc_loop_sel_s      loopSel,          // Selectors to the loop
    output logic               cmlSummary,       // CML bit of status byte
    output logic               cmlInvalidCmd,    // Invalid command flag
    output logic               faultNotify       // Host alert request
);

    // =================================================================
    // Reset release
    // =================================================================
    logic rstSync1_r;  // First release stage
    logic rstSync2_r;  // Released reset seen by the design
    logic rstnInt;     // Internal active-low reset

    // Two-stage release so every flop leaves reset on the same edge
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end else begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end
    assign rstnInt = rstSync2_r;

    // =================================================================
    // Command decode
    // =================================================================
    wire        hitRev     = cmdIn.valid &&
                             (cmdIn.code == RLC_CMD_SILICON_REV);
    wire        hitComp    = cmdIn.valid && (cmdIn.code == RLC_CMD_LOOP_COMP);
    wire        revRead    = hitRev && !cmdIn.write;
    wire        revWrite   = hitRev && cmdIn.write;
    wire        compCntOk  = cmdIn.byteCount == RLC_COMP_BYTES;
    wire        compWrite  = hitComp && cmdIn.write && compCntOk;
    wire        compBadCnt = hitComp && cmdIn.write && !compCntOk;
    wire        compRead   = hitComp && !cmdIn.write;
    wire        cmdHit     = hitRev || hitComp;             // Ours at all

    // Revision word built from its fields, never writable
    wire [15:0] revWord = {MAJOR_REVISION, MINOR_REVISION,
                           SUBMINOR_REVISION};

    // Strap or NVM source chosen by the override mask; a cleared bit
    // lets a restore bring back the stored image written while running
    wire [39:0] loadWord = strapOverrideMask ? strapWord : nvmWord;

    // =================================================================
    // Readback copy and applied copy
    // =================================================================
    logic [39:0] compWord_r;    // Word the host reads back
    logic [39:0] compWord_nxt;
    logic [39:0] applied_r;     // Word the loop actually uses
    logic [39:0] applied_nxt;

    // Restore always reaches hardware; a write only when conversion is off
    wire applyWrite = compWrite && !conversionOn;
    assign compWord_nxt = restoreLoad ? loadWord :
                          compWrite   ? cmdIn.data : compWord_r;
    assign applied_nxt  = restoreLoad ? loadWord :
                          applyWrite  ? cmdIn.data : applied_r;

    // Word registers: reserved bits stored as written, host keeps them 0
    always_ff @(posedge clk_sys or negedge rstnInt) begin
        if (!rstnInt) begin
            compWord_r <= RLC_COMP_RESET;
            applied_r  <= RLC_COMP_RESET;
        end else begin
            compWord_r <= compWord_nxt;
            applied_r  <= applied_nxt;
        end
    end

    // =================================================================
    // Selector decode of the applied word
    // =================================================================
    rlc_loop_sel_s selNxt;  // Decoded fields of the next applied word

    assign selNxt.curIntegCapSel   = {applied_nxt[RLC_CZI_HI_H:RLC_CZI_HI_L],
                                      applied_nxt[RLC_CZI_LO_H:RLC_CZI_LO_L]};
    assign selNxt.curFilterCapSel  = applied_nxt[RLC_CPI_H:RLC_CPI_L];
    assign selNxt.curIntegCapDoubler = applied_nxt[RLC_CZI_MUL];
    assign selNxt.curGainResSel    = applied_nxt[RLC_RVI_H:RLC_RVI_L];
    assign selNxt.voltIntegCapSel  = {applied_nxt[RLC_CZV_HI_H:RLC_CZV_HI_L],
                                      applied_nxt[RLC_CZV_LO_H:RLC_CZV_LO_L]};
    assign selNxt.voltFilterCapSel = applied_nxt[RLC_CPV_H:RLC_CPV_L];
    assign selNxt.voltGainResSel   = applied_nxt[RLC_RVV_H:RLC_RVV_L];
    assign selNxt.voltTranscondSel = applied_nxt[RLC_GMV_H:RLC_GMV_L];
    assign selNxt.curTranscondSel  = applied_nxt[RLC_GMI_H:RLC_GMI_L];

    // Selector outputs registered so the loop never sees decode glitches
    always_ff @(posedge clk_sys or negedge rstnInt) begin
        if (!rstnInt) begin
            loopSel <= '0;
        end else begin
            loopSel <= selNxt;
        end
    end

    // =================================================================
    // Answer path
    // =================================================================
    rlc_rsp_s rspNxt;  // Answer formed this cycle

    assign rspNxt.valid     = cmdHit;
    // Refuse revision writes and mis-sized compensation writes
    assign rspNxt.accept    = revRead || compRead || compWrite;
    assign rspNxt.byteCount = revRead  ? RLC_REV_BYTES :
                              compRead ? RLC_COMP_BYTES : 8'h00;
    assign rspNxt.data      = revRead  ? {24'h00_0000, revWord} :
                              compRead ? compWord_r : 40'h00_0000_0000;

    // One-cycle answer, one edge after the command
    always_ff @(posedge clk_sys or negedge rstnInt) begin
        if (!rstnInt) begin
            rspOut <= '0;
        end else begin
            rspOut <= rspNxt;
        end
    end

    // =================================================================
    // Communication fault flags
    // =================================================================
    logic cmlSummary_nxt;   // Status byte CML bit
    logic cmlIvc_nxt;       // Invalid command bit 7

    // A fault in the clearing cycle survives: set wins over clear
    assign cmlIvc_nxt     = revWrite || (cmlInvalidCmd && !clearFaults);
    assign cmlSummary_nxt = revWrite || compBadCnt ||
                            (cmlSummary && !clearFaults);

    // Sticky flags plus the alert that follows them
    always_ff @(posedge clk_sys or negedge rstnInt) begin
        if (!rstnInt) begin
            cmlInvalidCmd <= 1'b0;
            cmlSummary    <= 1'b0;
            faultNotify   <= 1'b0;
        end else begin
            cmlInvalidCmd <= cmlIvc_nxt;
            cmlSummary    <= cmlSummary_nxt;
            // Alert held while any CML fault stands
            faultNotify   <= cmlSummary_nxt;
        end
    end

    // =================================================================
    // Checks
    // =================================================================
    // Revision read answered with two bytes, one edge later
    rev_len_a: assert property (
        @(posedge clk_sys) disable iff (!rstnInt)
        revRead |=> rspOut.valid && rspOut.accept &&
                    rspOut.byteCount == RLC_REV_BYTES)
        else $error("Revision read not answered with two bytes");

    // Revision fields at their fixed places
    rev_fields_a: assert property (
        @(posedge clk_sys) disable iff (!rstnInt)
        revRead |=> rspOut.data[RLC_MAJOR_HI:RLC_MAJOR_LO] == MAJOR_REVISION
            && rspOut.data[RLC_MINOR_HI:RLC_MINOR_LO] == MINOR_REVISION
            && rspOut.data[RLC_SUBMN_HI:RLC_SUBMN_LO] == SUBMINOR_REVISION)
        else $error("Revision fields misplaced");

    // Revision write refused and flagged
    ivc_set_a: assert property (
        @(posedge clk_sys) disable iff (!rstnInt)
        revWrite |=> cmlInvalidCmd && cmlSummary && !rspOut.accept)
        else $error("Revision write did not raise invalid command");

    // Alert raised, and still up one edge later unless a clear was taken on that edge
    fault_notify_a: assert property (
        @(posedge clk_sys) disable iff (!rstnInt)
        revWrite |=> faultNotify ##1 (faultNotify || $past(clearFaults)))
        else $error("Invalid command not notified");

    // Alert never parts from the summary bit
    notify_follow_a: assert property (
        @(posedge clk_sys) disable iff (!rstnInt)
        faultNotify == cmlSummary)
        else $error("Alert does not follow the CML summary");

    // Readback returns the held word, five bytes
    comp_read_a: assert property (
        @(posedge clk_sys) disable iff (!rstnInt)
        compRead |=> rspOut.byteCount == RLC_COMP_BYTES &&
                     rspOut.data == $past(compWord_r))
        else $error("Compensation read wrong");

    // Wrong length refused; neither copy moves
    bad_count_a: assert property (
        @(posedge clk_sys) disable iff (!rstnInt)
        compBadCnt && !restoreLoad |=> cmlSummary && !rspOut.accept &&
            $stable(compWord_r) && $stable(applied_r))
        else $error("Mis-sized compensation write not refused");

    // Exactly one answer per command of ours
    answer_strobe_a: assert property (
        @(posedge clk_sys) disable iff (!rstnInt)
        1'b1 |=> rspOut.valid == $past(cmdHit))
        else $error("Answer strobe does not follow the command");

    // Conversion off: written word reaches the loop
    apply_off_a: assert property (
        @(posedge clk_sys) disable iff (!rstnInt)
        compWrite && !conversionOn && !restoreLoad |=>
            applied_r == $past(cmdIn.data) &&
            loopSel.curTranscondSel == $past(cmdIn.data[RLC_GMI_H:RLC_GMI_L]))
        else $error("Write with conversion off not applied");

    // Conversion on: only the readback copy moves
    block_on_a: assert property (
        @(posedge clk_sys) disable iff (!rstnInt)
        compWrite && conversionOn && !restoreLoad |=>
            $stable(applied_r) && compWord_r == $past(cmdIn.data))
        else $error("Write with conversion on leaked to hardware");

    // Load takes the source the mask stood for at the pulse
    load_src_a: assert property (
        @(posedge clk_sys) disable iff (!rstnInt)
        restoreLoad |=> applied_r == ($past(strapOverrideMask) ?
            $past(strapWord) : $past(nvmWord)))
        else $error("Load took the wrong source");

    // Split selectors assembled from both pairs
    cur_cap_a: assert property (
        @(posedge clk_sys) disable iff (!rstnInt)
        loopSel.curIntegCapSel == {applied_r[RLC_CZI_HI_H:RLC_CZI_HI_L],
            applied_r[RLC_CZI_LO_H:RLC_CZI_LO_L]} &&
        loopSel.voltIntegCapSel == {applied_r[RLC_CZV_HI_H:RLC_CZV_HI_L],
            applied_r[RLC_CZV_LO_H:RLC_CZV_LO_L]})
        else $error("Split capacitor selectors misassembled");

    // Plain selector fields other than current gm follow the applied copy
    sel_fields_a: assert property (
        @(posedge clk_sys) disable iff (!rstnInt)
        loopSel.curFilterCapSel == applied_r[RLC_CPI_H:RLC_CPI_L] &&
        loopSel.curIntegCapDoubler == applied_r[RLC_CZI_MUL] &&
        loopSel.curGainResSel == applied_r[RLC_RVI_H:RLC_RVI_L] &&
        loopSel.voltFilterCapSel == applied_r[RLC_CPV_H:RLC_CPV_L] &&
        loopSel.voltGainResSel == applied_r[RLC_RVV_H:RLC_RVV_L] &&
        loopSel.voltTranscondSel == applied_r[RLC_GMV_H:RLC_GMV_L])
        else $error("Selector field misplaced");

    // Fault in the clearing cycle survives
    set_wins_a: assert property (
        @(posedge clk_sys) disable iff (!rstnInt)
        revWrite && clearFaults |=> cmlInvalidCmd)
        else $error("Clear beat a simultaneous fault");

    // Clear with no new fault drops every flag
    flag_clear_a: assert property (
        @(posedge clk_sys) disable iff (!rstnInt)
        clearFaults && !revWrite && !compBadCnt |=>
            !cmlSummary && !cmlInvalidCmd && !faultNotify)
        else $error("Fault flags survived a clear");

endmodule // rlc_bank

// ==== rlc_host_model.sv ====
`timescale 1ns/10ps

// =============================================================
// Host stand-in: PMBus block transfers and the stored user image
// =============================================================
module rlc_host_model
    import rlc_pkg::*;
(
    input  wire logic     clk_sys,           // Device clock
    input  wire rlc_rsp_s rspOut,            // Answer from the bank
    output rlc_cmd_s      cmdIn,             // Command to the bank
    output logic          restoreLoad,       // Restore-all pulse
    output logic [39:0]   nvmWord,           // Stored user image
    output logic          strapOverrideMask, // 0 takes stored image
    output logic          clearFaults        // Clear-faults pulse
);
    // Idle lines at time zero
    initial begin
        cmdIn = '0;
        restoreLoad = 1'b0;
        nvmWord = 40'h00_0000_0000;
        strapOverrideMask = 1'b0;
        clearFaults = 1'b0;
    end

    // One transfer; the answer stands only in the cycle after the take
    task automatic xfer(input logic wr, input logic [7:0] code,
                        input logic [7:0] cnt, input logic [39:0] d,
                        output rlc_rsp_s r);
        if (wr && code == RLC_CMD_LOOP_COMP) begin
            d = d & ~40'h00_0001_00cc;
        end
        @(posedge clk_sys);
        cmdIn <= '{1'b1, wr, code, cnt, d};
        @(posedge clk_sys);
        // Released lines scrambled so stale data cannot pass as valid
        cmdIn <= '{1'b0, ~wr, ~code, ~cnt, ~d};
        #1 r = rspOut;
    endtask

    // Store image, set or clear override bit, restore
    task automatic restore(input logic [39:0] img, input logic mask);
        @(posedge clk_sys);
        nvmWord <= img;
        strapOverrideMask <= mask;
        restoreLoad <= 1'b1;
        @(posedge clk_sys);
        restoreLoad <= 1'b0;
        #1;
    endtask

    // Single clear-faults pulse
    task automatic clear();
        @(posedge clk_sys);
        clearFaults <= 1'b1;
        @(posedge clk_sys);
        clearFaults <= 1'b0;
        #1;
    endtask
endmodule // rlc_host_model

// ==== rlc_bank_bench.sv ====
`timescale 1ns/10ps

// =============================================================
// Self-checking bench for the revision / compensation bank
// =============================================================
module rlc_bank_bench
    import rlc_pkg::*;
;
    localparam logic [3:0] MAJ = 4'h3;  // Arbitrary value
    localparam logic [3:0] MIN = 4'h9;  // Arbitrary value
    localparam logic [7:0] SUB = 8'h5a; // Arbitrary value
    localparam int         CAP = 3000;  // Run takes about 73 cycles

    logic          clk_sys = 1'b0;      // 10 MHz clock
    logic          rstn = 1'b0;         // Reset, active low
    logic          conversionOn = 1'b0; // Converter running
    logic [39:0]   strapWord = '0;      // Strap detection result
    rlc_cmd_s      cmdIn;               // Host command
    rlc_rsp_s      rspOut, r;           // Answer, captured answer
    rlc_loop_sel_s loopSel;             // Applied selectors
    logic          restoreLoad, clearFaults, strapOverrideMask;
    logic [39:0]   nvmWord, w, held;    // Image, words in flight
    logic          cmlSummary, cmlInvalidCmd, faultNotify;
    logic [31:0]   seed = 32'd93;       // Fixed seed, repeatable
    int            errTotal = 0, checksDone = 0, cycles = 0;
    logic [39:0]   corner [4] = '{40'hc0_0000_0000, 40'h00_0300_0000,
                                  40'h00_00c0_0300, 40'hff_fffe_ff33};

    always #50 clk_sys = ~clk_sys;

    rlc_bank #(.MAJOR_REVISION(MAJ), .MINOR_REVISION(MIN),
               .SUBMINOR_REVISION(SUB)) rlc_bank_inst (
        .clk_sys(clk_sys), .rstn(rstn), .cmdIn(cmdIn),
        .conversionOn(conversionOn), .restoreLoad(restoreLoad),
        .nvmWord(nvmWord), .strapWord(strapWord),
        .strapOverrideMask(strapOverrideMask), .clearFaults(clearFaults),
        .rspOut(rspOut), .loopSel(loopSel), .cmlSummary(cmlSummary),
        .cmlInvalidCmd(cmlInvalidCmd), .faultNotify(faultNotify));

    rlc_host_model rlc_host_model_inst (
        .clk_sys(clk_sys), .rspOut(rspOut), .cmdIn(cmdIn),
        .restoreLoad(restoreLoad), .nvmWord(nvmWord),
        .strapOverrideMask(strapOverrideMask), .clearFaults(clearFaults));

    // xorshift generator; reserved bits left clear for host writes
    function automatic logic [39:0] rndWord();
        logic [31:0] a;
        logic [7:0]  b;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        a = seed;
        b = seed[23:16] ^ seed[7:0];
        return {b, a} & ~40'h00_0001_00cc;
    endfunction

    // Expected selectors from a compensation word
    function automatic rlc_loop_sel_s decode(input logic [39:0] v);
        decode.curIntegCapSel = {v[25:24], v[39:38]};
        decode.curFilterCapSel = v[37:33];
        decode.curIntegCapDoubler = v[32];
        decode.curGainResSel = v[31:26];
        decode.voltIntegCapSel = {v[9:8], v[23:22]};
        decode.voltFilterCapSel = v[21:17];
        decode.voltGainResSel = v[15:10];
        decode.voltTranscondSel = v[5:4];
        decode.curTranscondSel = v[1:0];
    endfunction

    // Compare tasks: data values, selectors, flags
    task automatic chkVal(input string n, input logic [39:0] e, g);
        checksDone++;
        if (g !== e) begin
            errTotal++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chkSel(input string n, input rlc_loop_sel_s e, g);
        chkVal(n, {4'h0, e}, {4'h0, g});
    endtask
    task automatic chkFlag(input string n, input logic e, g);
        chkVal(n, {39'h0, e}, {39'h0, g});
    endtask

    // Verdict and end of run
    task automatic testDone();
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == CAP) begin
            errTotal++;
            testDone();
        end
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chkSel("reset sel", '0, loopSel);
        chkFlag("reset summary", 1'b0, cmlSummary);
        // Revision read: two bytes, fixed field layout
        rlc_host_model_inst.xfer(1'b0, RLC_CMD_SILICON_REV, 8'h00, '0, r);
        chkFlag("rev valid", 1'b1, r.valid);
        chkFlag("rev accept", 1'b1, r.accept);
        chkVal("rev count", 40'h2, {32'h0, r.byteCount});
        chkVal("rev data", {24'h0, MAJ, MIN, SUB}, r.data);
        $display("test revision done");
        // Power-on load from strap, then from stored image
        for (int m = 0; m < 2; m++) begin
            w = rndWord();
            held = rndWord();
            @(posedge clk_sys) strapWord <= w;
            rlc_host_model_inst.restore(held, !m[0]);
            w = m[0] ? held : w;
            chkSel("load sel", decode(w), loopSel);
            rlc_host_model_inst.xfer(1'b0, RLC_CMD_LOOP_COMP, 8'h00, '0, r);
            chkVal("load back", w, r.data);
            chkVal("load count", 40'h5, {32'h0, r.byteCount});
        end
        $display("test load done");
        // Conversion off: corners then random words apply at once
        for (int i = 0; i < 8; i++) begin
            w = (i < 4) ? corner[i] : rndWord();
            rlc_host_model_inst.xfer(1'b1, RLC_CMD_LOOP_COMP, 8'h05, w, r);
            chkFlag("wr accept", 1'b1, r.accept);
            chkSel("wr sel", decode(w), loopSel);
            rlc_host_model_inst.xfer(1'b0, RLC_CMD_LOOP_COMP, 8'h00, '0, r);
            chkVal("wr back", w, r.data);
        end
        $display("test direct write done");
        // Conversion on: held for readback, loop untouched until restore
        @(posedge clk_sys) conversionOn <= 1'b1;
        held = rndWord();
        rlc_host_model_inst.xfer(1'b1, RLC_CMD_LOOP_COMP, 8'h05, held, r);
        chkSel("blocked sel", decode(w), loopSel);
        rlc_host_model_inst.xfer(1'b0, RLC_CMD_LOOP_COMP, 8'h00, '0, r);
        chkVal("blocked back", held, r.data);
        rlc_host_model_inst.restore(r.data, 1'b0);
        chkSel("restored sel", decode(held), loopSel);
        $display("test blocked write done");
        // Write to the read-only revision command
        rlc_host_model_inst.xfer(1'b1, RLC_CMD_SILICON_REV, 8'h02,
                                 rndWord(), r);
        chkFlag("ro accept", 1'b0, r.accept);
        chkVal("ro count", 40'h0, {32'h0, r.byteCount});
        chkFlag("ro invalid", 1'b1, cmlInvalidCmd);
        chkFlag("ro summary", 1'b1, cmlSummary);
        chkFlag("ro notify", 1'b1, faultNotify);
        rlc_host_model_inst.clear();
        chkFlag("clr notify", 1'b0, faultNotify);
        chkFlag("clr invalid", 1'b0, cmlInvalidCmd);
        chkFlag("clr summary", 1'b0, cmlSummary);
        $display("test read-only write done");
        // Short block write is refused, word kept
        @(posedge clk_sys) conversionOn <= 1'b0;
        rlc_host_model_inst.xfer(1'b1, RLC_CMD_LOOP_COMP, 8'h04,
                                 rndWord(), r);
        chkFlag("short accept", 1'b0, r.accept);
        chkFlag("short summary", 1'b1, cmlSummary);
        chkFlag("short invalid", 1'b0, cmlInvalidCmd);
        chkSel("short sel", decode(held), loopSel);
        rlc_host_model_inst.xfer(1'b0, RLC_CMD_LOOP_COMP, 8'h00, '0, r);
        chkVal("short back", held, r.data);
        rlc_host_model_inst.clear();
        $display("test short write done");
        // Fault and clear taken on one edge: the fault must survive
        fork
            rlc_host_model_inst.xfer(1'b1, RLC_CMD_SILICON_REV, 8'h02,
                                     '0, r);
            rlc_host_model_inst.clear();
        join
        chkFlag("same invalid", 1'b1, cmlInvalidCmd);
        chkFlag("same notify", 1'b1, faultNotify);
        rlc_host_model_inst.clear();
        chkFlag("late invalid", 1'b0, cmlInvalidCmd);
        $display("test set wins done");
        testDone();
    end
endmodule // rlc_bank_bench
